// >>> design/csc_pkg.sv
package csc_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam int CSC_AW = 4;
  localparam int CSC_DW = 8;
  localparam logic [3:0] CSC_OFS_INT_OSC_MODE = 4'h0; // internal_osc_mode_reg
  localparam logic [3:0] CSC_OFS_PROC_CLK_CTRL = 4'h1; // processor_clock_ctrl_reg
  localparam logic [3:0] CSC_OFS_CLK_OP_MODE = 4'h2; // clock_op_mode_reg
  localparam logic [3:0] CSC_OFS_MAIN_CLK_MODE = 4'h3; // main_clock_mode_reg

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int CSC_B_HS_STABLE = 7;
  localparam int CSC_B_LS_STOP = 1;
  localparam int CSC_B_HS_STOP = 0;
  localparam int CSC_B_XTAL_START = 6;
  localparam int CSC_B_SUB_STATUS = 5;
  localparam int CSC_B_CPU_SUB_SEL = 4;
  localparam int CSC_B_DIV_MSB = 2;
  localparam int CSC_B_EXT_MAIN = 7;
  localparam int CSC_B_EXT_SUB = 5;
  localparam int CSC_B_SUB_EN = 4;
  localparam int CSC_B_HS_SEL = 2;
  localparam int CSC_B_MAIN_STATUS = 1;
  localparam int CSC_B_MAIN_SEL = 0;

  // ********************************************************
  // reset values and codes
  // ********************************************************
  localparam logic [2:0] CSC_DIV_RST = 3'h1;
  localparam logic [2:0] CSC_DIV_MAX = 3'h4;
  localparam int CSC_NSRC = 4;
  localparam logic [1:0] CSC_SRC_HS_INT = 2'h0;
  localparam logic [1:0] CSC_SRC_XTAL_MAIN = 2'h1;
  localparam logic [1:0] CSC_SRC_EXT_MAIN = 2'h2;
  localparam logic [1:0] CSC_SRC_SUB = 2'h3;

endpackage

// >>> design/csc_clk_switch.sv
`timescale 1ns/1ps
// glitch-free selection among source tick streams
module csc_clk_switch #(
  parameter int NSRC = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic ce, // clock enable
  input wire logic [NSRC-1:0] src_tick, // one tick per source edge
  input wire logic [1:0] sel, // requested source
  output logic tick_r, // selected tick stream
  output logic [1:0] cur_r // source actually in use
);
  import csc_pkg::*;

  typedef enum logic [1:0] {CSC_SW_RUN, CSC_SW_OLD, CSC_SW_NEW} csc_sw_t;
  csc_sw_t st_r;
  csc_sw_t st_nxt;
  logic [1:0] cur_nxt;

  // ********************************************************
  // switch sequencing
  // ********************************************************
  wire old_tick = src_tick[cur_r];
  wire new_tick = src_tick[sel];

  // safe point handover
  // the old stream is released on its own tick, the new one is taken on its own
  // tick, so no shortened pulse reaches the consumer
  always_comb begin
    st_nxt = st_r;
    cur_nxt = cur_r;
    case (st_r)
      CSC_SW_RUN: begin
        if (sel != cur_r && old_tick) begin
          st_nxt = CSC_SW_NEW;
        end else if (sel != cur_r) begin
          st_nxt = CSC_SW_OLD;
        end
      end
      CSC_SW_OLD: begin
        if (old_tick) begin
          st_nxt = CSC_SW_NEW;
        end
      end
      CSC_SW_NEW: begin
        if (new_tick) begin
          st_nxt = CSC_SW_RUN;
          cur_nxt = sel;
        end
      end
      default: begin
        st_nxt = CSC_SW_RUN;
      end
    endcase
  end

  // output gated while a handover is pending
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= CSC_SW_RUN;
      cur_r <= CSC_SRC_HS_INT;
      tick_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      cur_r <= cur_nxt;
      tick_r <= (st_r == CSC_SW_RUN) && (sel == cur_r) && old_tick;
    end
  end

endmodule

// >>> design/csc_top.sv
`timescale 1ns/1ps
module csc_top (
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic [csc_pkg::CSC_AW-1:0] reg_addr, // register address
  input wire logic [csc_pkg::CSC_DW-1:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [csc_pkg::CSC_DW-1:0] reg_rdata_r, // read data, cycle after strobe
  input wire logic hs_int_tick, // internal high-speed oscillator tick
  input wire logic hs_osc_ready, // internal high-speed accuracy settled
  input wire logic xtal_main_tick, // main crystal tick
  input wire logic ext_main_tick, // external main clock tick
  input wire logic sub_crystal_tick, // subsystem crystal tick
  input wire logic sub_ext_tick, // external subsystem clock tick on second pin
  input wire logic ls_tick, // low-speed oscillator tick (30 kHz typ)
  input wire logic stop_mode, // STOP instruction in effect
  input wire logic wdt_enable_cfg, // watchdog enabled by configuration
  input wire logic ls_nonstop_cfg, // low-speed oscillator not stoppable
  input wire logic tmr8_ls_select, // 8-bit timer counts low-speed clock
  output logic hs_osc_run_r, // internal high-speed oscillator enable
  output logic ls_osc_run_r, // low-speed oscillator enable
  output logic sub_xtal_mode_r, // subsystem pins in crystal mode
  output logic sub_ext_mode_r, // second pin takes external clock
  output logic sub_crystal_in_pin_port_r, // first pin is input port
  output logic sub_crystal_out_pin_port_r, // second pin is input port
  output logic cpu_clk_tick_r, // CPU clock tick
  output logic periph_clk_tick_r, // peripheral clock tick
  output logic wdt_clk_tick_r, // watchdog clock tick
  output logic tmr8_clk_tick_r // 8-bit timer low-speed tick
);
  import csc_pkg::*;

  // ********************************************************
  // reset release
  // ********************************************************
  logic rst_meta_r;
  logic rst_n;

  // two-stage release so removal meets timing
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ********************************************************
  // control registers
  // ********************************************************
  logic hs_osc_stop_r;
  logic low_speed_osc_stop_r;
  logic crystal_start_r;
  logic cpu_subclock_select_r;
  logic [2:0] cpu_div_r;
  logic external_main_select_r;
  logic external_subclock_select_r;
  logic subclock_enable_r;
  logic high_speed_select_r;
  logic main_source_select_r;

  wire wr_rcm = reg_wr && (reg_addr == CSC_OFS_INT_OSC_MODE);
  wire wr_pcc = reg_wr && (reg_addr == CSC_OFS_PROC_CLK_CTRL);
  wire wr_occ = reg_wr && (reg_addr == CSC_OFS_CLK_OP_MODE);
  wire wr_mcm = reg_wr && (reg_addr == CSC_OFS_MAIN_CLK_MODE);
  wire [2:0] div_wr = reg_wdata[CSC_B_DIV_MSB:0];
  // prohibited divider codes are dropped, the old ratio stays
  wire div_ok = (div_wr <= CSC_DIV_MAX);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hs_osc_stop_r <= 1'b0;
      low_speed_osc_stop_r <= 1'b0;
      crystal_start_r <= 1'b0;
      cpu_subclock_select_r <= 1'b0;
      cpu_div_r <= CSC_DIV_RST;
      external_main_select_r <= 1'b0;
      external_subclock_select_r <= 1'b0;
      subclock_enable_r <= 1'b0;
      high_speed_select_r <= 1'b0;
      main_source_select_r <= 1'b0;
    end else if (ce) begin
      if (wr_rcm) begin
        hs_osc_stop_r <= reg_wdata[CSC_B_HS_STOP];
        low_speed_osc_stop_r <= reg_wdata[CSC_B_LS_STOP];
      end
      if (wr_pcc) begin
        crystal_start_r <= reg_wdata[CSC_B_XTAL_START];
        cpu_subclock_select_r <= reg_wdata[CSC_B_CPU_SUB_SEL];
      end
      if (wr_pcc && div_ok) begin
        cpu_div_r <= div_wr;
      end
      if (wr_occ) begin
        external_main_select_r <= reg_wdata[CSC_B_EXT_MAIN];
        external_subclock_select_r <= reg_wdata[CSC_B_EXT_SUB];
        subclock_enable_r <= reg_wdata[CSC_B_SUB_EN];
      end
      if (wr_mcm) begin
        high_speed_select_r <= reg_wdata[CSC_B_HS_SEL];
        main_source_select_r <= reg_wdata[CSC_B_MAIN_SEL];
      end
    end
  end

  // ********************************************************
  // oscillator and pin control
  // ********************************************************
  // stop bit halts oscillator, except the low-speed one while ls_nonstop_cfg is set
  // STOP mode also halts the high-speed one; the low-speed and subsystem paths never look at stop_mode
  wire hs_run_nxt = !hs_osc_stop_r && !stop_mode;
  wire ls_run_nxt = ls_nonstop_cfg || !low_speed_osc_stop_r;
  wire xtal_mode = crystal_start_r || (!external_subclock_select_r && subclock_enable_r);
  wire ext_mode = !crystal_start_r && external_subclock_select_r && subclock_enable_r;
  wire sub_tick = (xtal_mode && sub_crystal_tick) || (ext_mode && sub_ext_tick);
  // stopped sources deliver no ticks, so switches wait rather than glitch
  wire hs_int_live = hs_int_tick && hs_osc_run_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hs_osc_run_r <= 1'b1;
      ls_osc_run_r <= 1'b1;
      sub_xtal_mode_r <= 1'b0;
      sub_ext_mode_r <= 1'b0;
      sub_crystal_in_pin_port_r <= 1'b1;
      sub_crystal_out_pin_port_r <= 1'b1;
    end else if (ce) begin
      hs_osc_run_r <= hs_run_nxt;
      ls_osc_run_r <= ls_run_nxt;
      sub_xtal_mode_r <= xtal_mode;
      sub_ext_mode_r <= ext_mode;
      sub_crystal_in_pin_port_r <= !xtal_mode;
      sub_crystal_out_pin_port_r <= !xtal_mode && !ext_mode;
    end
  end

  // ********************************************************
  // source selection
  // ********************************************************
  logic [CSC_NSRC-1:0] src_tick;
  logic [1:0] cpu_sel;
  logic [1:0] per_sel;
  logic [1:0] hs_sys_src;
  logic [1:0] cpu_cur;
  logic [1:0] per_cur;
  logic cpu_raw_tick;
  logic per_raw_tick;

  assign src_tick = {sub_tick, ext_main_tick, xtal_main_tick, hs_int_live};
  assign hs_sys_src = external_main_select_r ? CSC_SRC_EXT_MAIN : CSC_SRC_XTAL_MAIN;
  assign cpu_sel = cpu_subclock_select_r ? CSC_SRC_SUB :
                   (high_speed_select_r && main_source_select_r) ? hs_sys_src : CSC_SRC_HS_INT;
  assign per_sel = high_speed_select_r ? hs_sys_src : CSC_SRC_HS_INT;

  csc_clk_switch #(
    .NSRC(CSC_NSRC)
  ) u_cpu_sw (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .src_tick(src_tick),
    .sel(cpu_sel),
    .tick_r(cpu_raw_tick),
    .cur_r(cpu_cur)
  );

  csc_clk_switch #(
    .NSRC(CSC_NSRC)
  ) u_per_sw (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .src_tick(src_tick),
    .sel(per_sel),
    .tick_r(per_raw_tick),
    .cur_r(per_cur)
  );

  // ********************************************************
  // cpu divider and clock outputs
  // ********************************************************
  logic [3:0] div_cnt_r;
  wire on_sub = (cpu_cur == CSC_SRC_SUB);
  wire [3:0] div_mask = 4'(({1'b0, 4'h1} << cpu_div_r) - 5'h01);
  wire cpu_tick_nxt = cpu_raw_tick && (on_sub || ((div_cnt_r & div_mask) == div_mask));

  // divider counts every non-subsystem tick (internal high-speed, crystal and external main) so the ratio holds across switches
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= 4'h0;
      cpu_clk_tick_r <= 1'b0;
      periph_clk_tick_r <= 1'b0;
      wdt_clk_tick_r <= 1'b0;
      tmr8_clk_tick_r <= 1'b0;
    end else if (ce) begin
      if (cpu_raw_tick && !on_sub) begin
        div_cnt_r <= div_cnt_r + 4'h1;
      end
      cpu_clk_tick_r <= cpu_tick_nxt;
      periph_clk_tick_r <= per_raw_tick;
      wdt_clk_tick_r <= ls_tick && ls_osc_run_r && wdt_enable_cfg;
      tmr8_clk_tick_r <= ls_tick && ls_osc_run_r && tmr8_ls_select;
    end
  end

  // ********************************************************
  // register read back
  // ********************************************************
  logic [CSC_DW-1:0] rd_mux;

  // status from completed switch
  // status reads cur, not the request, so it flips only after handover
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      CSC_OFS_INT_OSC_MODE: begin
        rd_mux[CSC_B_HS_STABLE] = hs_osc_ready && hs_osc_run_r;
        rd_mux[CSC_B_LS_STOP] = low_speed_osc_stop_r;
        rd_mux[CSC_B_HS_STOP] = hs_osc_stop_r;
      end
      CSC_OFS_PROC_CLK_CTRL: begin
        rd_mux[CSC_B_XTAL_START] = crystal_start_r;
        rd_mux[CSC_B_SUB_STATUS] = on_sub;
        rd_mux[CSC_B_CPU_SUB_SEL] = cpu_subclock_select_r;
        rd_mux[CSC_B_DIV_MSB:0] = cpu_div_r;
      end
      CSC_OFS_CLK_OP_MODE: begin
        rd_mux[CSC_B_EXT_MAIN] = external_main_select_r;
        rd_mux[CSC_B_EXT_SUB] = external_subclock_select_r;
        rd_mux[CSC_B_SUB_EN] = subclock_enable_r;
      end
      CSC_OFS_MAIN_CLK_MODE: begin
        rd_mux[CSC_B_HS_SEL] = high_speed_select_r;
        rd_mux[CSC_B_MAIN_STATUS] = (cpu_cur == CSC_SRC_XTAL_MAIN) || (cpu_cur == CSC_SRC_EXT_MAIN);
        rd_mux[CSC_B_MAIN_SEL] = main_source_select_r;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // read data held only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (ce) begin
      reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // per_cur is kept for debug visibility of the peripheral handover
  wire per_unused = |per_cur;

endmodule

// >>> verif/csc_props.sv
`timescale 1ns/1ps
// ****************************************
// port-level checks of the clock source block
// ****************************************
module csc_props (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic [csc_pkg::CSC_AW-1:0] reg_addr, // register address
  input wire logic [csc_pkg::CSC_DW-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic stop_mode, // stop in effect
  input wire logic ls_tick, // low-speed tick
  input wire logic wdt_enable_cfg, // watchdog strap
  input wire logic ls_nonstop_cfg, // non-stoppable strap
  input wire logic tmr8_ls_select, // timer strap
  input wire logic hs_osc_run_r, // hs enable
  input wire logic ls_osc_run_r, // ls enable
  input wire logic sub_xtal_mode_r, // crystal mode
  input wire logic sub_ext_mode_r, // external mode
  input wire logic sub_crystal_in_pin_port_r, // first pin port
  input wire logic sub_crystal_out_pin_port_r, // second pin port
  input wire logic wdt_clk_tick_r, // watchdog tick
  input wire logic tmr8_clk_tick_r // timer tick
);
  import csc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // write to the oscillator mode register, both stop bits
  wire osc_wr = reg_wr && ce && reg_addr == CSC_OFS_INT_OSC_MODE;
  property p_hs_stop; osc_wr && reg_wdata[CSC_B_HS_STOP] |-> ##[1:2] !hs_osc_run_r; endproperty
  a_hs_stop: assert property (p_hs_stop) else $error("hs oscillator still enabled");
  property p_ls_stop; osc_wr && reg_wdata[CSC_B_LS_STOP] && !ls_nonstop_cfg |-> ##[1:2] !ls_osc_run_r; endproperty
  a_ls_stop: assert property (p_ls_stop) else $error("ls oscillator still enabled");
  property p_ls_keep; ls_nonstop_cfg [*2] |=> ls_osc_run_r; endproperty
  a_ls_keep: assert property (p_ls_keep) else $error("non-stoppable ls oscillator stopped");
  property p_wdt; wdt_clk_tick_r |-> $past(ls_tick) && $past(wdt_enable_cfg); endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog tick without ls tick");
  property p_tmr8; tmr8_clk_tick_r |-> $past(ls_tick) && $past(tmr8_ls_select); endproperty
  a_tmr8: assert property (p_tmr8) else $error("timer tick without ls tick");
  property p_ext_pins; sub_ext_mode_r |-> sub_crystal_in_pin_port_r && !sub_crystal_out_pin_port_r; endproperty
  a_ext_pins: assert property (p_ext_pins) else $error("pin use wrong in external mode");
  property p_xtal_pins; sub_xtal_mode_r |-> !sub_crystal_in_pin_port_r && !sub_crystal_out_pin_port_r; endproperty
  a_xtal_pins: assert property (p_xtal_pins) else $error("pin use wrong in crystal mode");
  // stop mode alone must never drop the subsystem oscillation
  property p_stop_sub; stop_mode && sub_xtal_mode_r && !reg_wr && !$past(reg_wr) |=> sub_xtal_mode_r; endproperty
  a_stop_sub: assert property (p_stop_sub) else $error("stop mode dropped subsystem clock");
  c_ext: cover property (sub_ext_mode_r);
  c_stop: cover property (stop_mode && sub_xtal_mode_r);
  c_tmr8: cover property (tmr8_clk_tick_r);
endmodule
bind csc_top csc_props csc_props_i (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .stop_mode(stop_mode), .ls_tick(ls_tick),
  .wdt_enable_cfg(wdt_enable_cfg), .ls_nonstop_cfg(ls_nonstop_cfg), .tmr8_ls_select(tmr8_ls_select),
  .hs_osc_run_r(hs_osc_run_r), .ls_osc_run_r(ls_osc_run_r), .sub_xtal_mode_r(sub_xtal_mode_r),
  .sub_ext_mode_r(sub_ext_mode_r), .sub_crystal_in_pin_port_r(sub_crystal_in_pin_port_r),
  .sub_crystal_out_pin_port_r(sub_crystal_out_pin_port_r), .wdt_clk_tick_r(wdt_clk_tick_r),
  .tmr8_clk_tick_r(tmr8_clk_tick_r));

// >>> verif/test_clock_source_control.sv
`timescale 1ns/1ps
module test_clock_source_control;
  import csc_pkg::*;
  logic clk_sys = 0, nrst = 0, ce = 1, reg_wr = 0, reg_rd = 0, hs_osc_ready = 1, stop_mode = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata_r, v;
  logic hs_int_tick = 0, xtal_main_tick = 0, ext_main_tick = 0, sub_crystal_tick = 0, sub_ext_tick = 0;
  logic ls_tick = 0, wdt_enable_cfg = 1, ls_nonstop_cfg = 0, tmr8_ls_select = 1;
  logic hs_osc_run_r, ls_osc_run_r, sub_xtal_mode_r, sub_ext_mode_r, pin_in_port, pin_out_port;
  logic cpu_clk_tick_r, periph_clk_tick_r, wdt_clk_tick_r, tmr8_clk_tick_r;
  int miscompares = 0, cmp_count = 0, cyc = 0, n_cpu = 0, n_per = 0, n_wdt = 0, n_tmr = 0, c, p, w, m;
  csc_top csc_top_i (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .hs_int_tick(hs_int_tick),
    .hs_osc_ready(hs_osc_ready), .xtal_main_tick(xtal_main_tick), .ext_main_tick(ext_main_tick),
    .sub_crystal_tick(sub_crystal_tick), .sub_ext_tick(sub_ext_tick), .ls_tick(ls_tick),
    .stop_mode(stop_mode), .wdt_enable_cfg(wdt_enable_cfg), .ls_nonstop_cfg(ls_nonstop_cfg),
    .tmr8_ls_select(tmr8_ls_select), .hs_osc_run_r(hs_osc_run_r), .ls_osc_run_r(ls_osc_run_r),
    .sub_xtal_mode_r(sub_xtal_mode_r), .sub_ext_mode_r(sub_ext_mode_r),
    .sub_crystal_in_pin_port_r(pin_in_port), .sub_crystal_out_pin_port_r(pin_out_port),
    .cpu_clk_tick_r(cpu_clk_tick_r), .periph_clk_tick_r(periph_clk_tick_r),
    .wdt_clk_tick_r(wdt_clk_tick_r), .tmr8_clk_tick_r(tmr8_clk_tick_r));
  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;
  // ****************************************
  // oscillator models: a stopped source gives no ticks
  // ****************************************
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    hs_int_tick <= cyc % 2 == 0 && hs_osc_run_r;
    xtal_main_tick <= cyc % 3 == 0;
    ext_main_tick <= cyc % 5 == 0;
    sub_crystal_tick <= cyc % 4 == 1 && sub_xtal_mode_r;
    sub_ext_tick <= cyc % 6 == 2 && sub_ext_mode_r;
    ls_tick <= cyc % 8 == 3 && ls_osc_run_r;
    n_cpu <= n_cpu + int'(cpu_clk_tick_r);
    n_per <= n_per + int'(periph_clk_tick_r);
    n_wdt <= n_wdt + int'(wdt_clk_tick_r);
    n_tmr <= n_tmr + int'(tmr8_clk_tick_r);
  end
  // ****************************************
  // shared checks and bus cycles
  // ****************************************
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task rng(input int got, input int lo, input int hi, input string m);
    cmp_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[ERR] %0t %s count %0d", $time, m, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 v = reg_rdata_r;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] exp, input string m);
    rd(a);
    chk(v, exp, m);
  endtask
  // switches finish within a few source periods
  task poll(input logic [3:0] a, input logic [7:0] msk, input logic [7:0] exp);
    for (int i = 0; i < 30; i++) begin
      rd(a);
      if ((v & msk) === exp) break;
    end
    chk(v & msk, exp, "status");
  endtask
  task cnt();
    int c0, p0, w0, m0;
    repeat (4) @(posedge clk_sys);
    c0 = n_cpu;
    p0 = n_per;
    w0 = n_wdt;
    m0 = n_tmr;
    repeat (48) @(posedge clk_sys);
    c = n_cpu - c0;
    p = n_per - p0;
    w = n_wdt - w0;
    m = n_tmr - m0;
  endtask
  task pins(input logic [7:0] exp);
    repeat (3) @(posedge clk_sys);
    chk({4'h0, sub_xtal_mode_r, sub_ext_mode_r, pin_in_port, pin_out_port}, exp, "pins");
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset();
    chk({6'h0, hs_osc_run_r, ls_osc_run_r}, 8'h03, "osc enables");
    pins(8'h03);
    rdc(CSC_OFS_INT_OSC_MODE, 8'h80, "osc reg");
    hs_osc_ready <= 0;
    rdc(CSC_OFS_INT_OSC_MODE, 8'h00, "stable flag");
    hs_osc_ready <= 1;
    rdc(CSC_OFS_PROC_CLK_CTRL, 8'h01, "proc reg");
    rdc(CSC_OFS_CLK_OP_MODE, 8'h00, "op reg");
    rdc(CSC_OFS_MAIN_CLK_MODE, 8'h00, "main reg");
    // read data must drop back to zero one cycle later
    @(posedge clk_sys);
    #1 chk(reg_rdata_r, 8'h00, "rdata stands one cycle");
    wr(4'h9, 8'hff);
    rdc(4'h9, 8'h00, "unmapped");
    cnt();
    rng(c, 11, 13, "cpu on hs");
    rng(p, 23, 25, "periph on hs");
    $display("reset test done");
  endtask
  task t_main();
    wr(CSC_OFS_MAIN_CLK_MODE, 8'h05);
    poll(CSC_OFS_MAIN_CLK_MODE, 8'h02, 8'h02);
    rdc(CSC_OFS_MAIN_CLK_MODE, 8'h07, "main reg");
    cnt();
    rng(c, 7, 9, "cpu on xtal div2");
    rng(p, 15, 17, "periph on xtal");
    // cpu and peripherals already moved off the internal oscillator
    wr(CSC_OFS_INT_OSC_MODE, 8'h01);
    repeat (3) @(posedge clk_sys);
    chk({7'h0, hs_osc_run_r}, 8'h00, "hs stop");
    rdc(CSC_OFS_INT_OSC_MODE, 8'h01, "osc reg");
    $display("main test done");
  endtask
  task t_sub();
    wr(CSC_OFS_CLK_OP_MODE, 8'h10);
    pins(8'h08);
    // stabilisation wait before the cpu relies on the crystal
    repeat (20) @(posedge clk_sys);
    wr(CSC_OFS_PROC_CLK_CTRL, 8'h13);
    poll(CSC_OFS_PROC_CLK_CTRL, 8'h20, 8'h20);
    wr(CSC_OFS_PROC_CLK_CTRL, 8'h17);
    rdc(CSC_OFS_PROC_CLK_CTRL, 8'h33, "bad divider");
    cnt();
    rng(c, 11, 13, "cpu on sub");
    rng(p, 15, 17, "periph kept");
    stop_mode <= 1;
    pins(8'h08);
    stop_mode <= 0;
    wr(CSC_OFS_PROC_CLK_CTRL, 8'h00);
    poll(CSC_OFS_PROC_CLK_CTRL, 8'h20, 8'h00);
    wr(CSC_OFS_CLK_OP_MODE, 8'h00);
    pins(8'h03);
    wr(CSC_OFS_CLK_OP_MODE, 8'h30);
    pins(8'h06);
    wr(CSC_OFS_CLK_OP_MODE, 8'h00);
    wr(CSC_OFS_PROC_CLK_CTRL, 8'h40);
    pins(8'h08);
    $display("sub test done");
  endtask
  task t_ls();
    wr(CSC_OFS_INT_OSC_MODE, 8'h03);
    repeat (3) @(posedge clk_sys);
    chk({7'h0, ls_osc_run_r}, 8'h00, "ls stop");
    // a write while the clock enable is low must not land
    ce <= 0;
    wr(CSC_OFS_INT_OSC_MODE, 8'h01);
    repeat (3) @(posedge clk_sys);
    chk({7'h0, ls_osc_run_r}, 8'h00, "frozen by clock enable");
    ce <= 1;
    wr(CSC_OFS_INT_OSC_MODE, 8'h01);
    repeat (3) @(posedge clk_sys);
    chk({7'h0, ls_osc_run_r}, 8'h01, "ls restart");
    ls_nonstop_cfg <= 1;
    wr(CSC_OFS_INT_OSC_MODE, 8'h03);
    repeat (3) @(posedge clk_sys);
    chk({7'h0, ls_osc_run_r}, 8'h01, "ls nonstop");
    cnt();
    rng(w, 5, 7, "watchdog ticks");
    rng(m, 5, 7, "timer ticks");
    wdt_enable_cfg <= 0;
    tmr8_ls_select <= 0;
    cnt();
    rng(w, 0, 0, "watchdog strap off");
    rng(m, 0, 0, "timer not on low speed");
    wdt_enable_cfg <= 1;
    tmr8_ls_select <= 1;
    $display("ls test done");
  endtask
  // external main clock, undivided; subsystem bits rewritten unchanged
  task t_ext();
    wr(CSC_OFS_CLK_OP_MODE, 8'h80);
    repeat (12) @(posedge clk_sys);
    rdc(CSC_OFS_MAIN_CLK_MODE, 8'h07, "main status on ext");
    cnt();
    rng(c, 9, 10, "cpu on ext undivided");
    rng(p, 9, 10, "periph on ext");
    $display("ext test done");
  endtask
  task conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence, reset held for five cycles
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_main();
    t_sub();
    t_ls();
    t_ext();
    conclude();
  end
  // watchdog, well beyond the expected run of under 2000 cycles
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule
